// ===== rtl/codec_ctl_defs.svh
// Constants for the codec mode and gain control register bank.
// Assumes inclusion by bare name from rtl/ sources.
`ifndef CODEC_CTL_DEFS_SVH
`define CODEC_CTL_DEFS_SVH

`define CW_RW_BIT 12
`define CW_REG_HI 11
`define CW_REG_LO 9
`define CW_DATA_HI 7
`define CW_DATA_LO 0
`define REG_NUM_MODE 3'h3
`define REG_NUM_GAIN 3'h4
`define MODE_RESET 8'h00
`define GAIN_RESET 8'h00
`define MODE_LOOP_HI 7
`define MODE_LOOP_LO 6
`define MODE_CONT_BIT 5
`define MODE_FSEL_BIT 4
`define MODE_FVAL_BIT 3
`define MODE_CHAN_HI 2
`define MODE_CHAN_LO 1
`define MODE_FMT_BIT 0
`define GAIN_ADC_HI 7
`define GAIN_ADC_LO 4
`define GAIN_DAC_HI 3
`define GAIN_DAC_LO 0

`endif

// ===== rtl/codec_ctl_pkg.sv
// Types for the codec mode and gain control register bank.
// Assumes the defines header is compiled alongside.
package codec_ctl_pkg;
   typedef enum logic [1:0] {LOOP_NONE, LOOP_ANALOG, LOOP_DIGITAL, LOOP_EVENT} loop_type;
   typedef enum logic [1:0] {CHAN_BOTH, CHAN_ADC_OFF, CHAN_DAC_OFF, CHAN_PWRDN} chan_type;
   // Signed gain in dB; mute reported separately
   typedef struct packed {
      logic mute;
      logic signed [7:0] db;
   } gain_type;
endpackage : codec_ctl_pkg

// ===== rtl/gain_if.sv
// Interface carrying one decoded amplifier gain between modules.
// Assumes the types package is compiled first.
`timescale 1ns/1ps
`default_nettype none
interface gain_if;
   logic [3:0] code;
   codec_ctl_pkg::gain_type gain;
   modport decoder (input code, output gain);
   modport user (output code, input gain);
endinterface : gain_if
`default_nettype wire

// ===== rtl/gain_decode.sv
// Decodes a 4-bit amplifier gain code into dB and a mute flag.
// Assumes the code input is a registered nibble on the same clock.
`timescale 1ns/1ps
`default_nettype none
module gain_decode (
   gain_if.decoder g
);
   import codec_ctl_pkg::*;

   function automatic gain_type decode_gain(input logic [3:0] code);
      gain_type r;
      r.mute = 1'b0;
      r.db = 8'sd0;
      case (code)
         4'hf: r.mute = 1'b1;
         4'he: r.db = 8'sd24;
         4'hd: r.db = 8'sd18;
         4'hc: r.db = 8'sd12;
         4'hb: r.db = 8'sd9;
         4'ha: r.db = 8'sd6;
         4'h9: r.db = 8'sd3;
         4'h8: r.db = -8'sd3;
         4'h7: r.db = -8'sd6;
         4'h6: r.db = -8'sd9;
         4'h5: r.db = -8'sd12;
         4'h4: r.db = -8'sd18;
         4'h3: r.db = -8'sd24;
         4'h2: r.db = -8'sd30;
         4'h1: r.db = -8'sd36;
         default: r.db = 8'sd0;
      endcase
      return r;
   endfunction : decode_gain

   assign g.gain = decode_gain(g.code);
endmodule : gain_decode
`default_nettype wire

// ===== rtl/codec_ctl_regs.sv
// Mode and gain control registers of the codec, written by 16-bit control words.
// Assumes word_valid is a one-cycle strobe from the serial deserialiser on clk.
// Assumes is_master and sec_comm_flag come from logic on the same clock.
// Reads and words for other register numbers are ignored; there is no read path.
// The flag pin is registered and lags its source by one cycle.
`timescale 1ns/1ps
`default_nettype none
`include "codec_ctl_defs.svh"
module codec_ctl_regs (
   input wire logic clk,
   input wire logic rst,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   input wire logic is_master,
   input wire logic sec_comm_flag,
   output logic [7:0] mode_reg,
   output logic [7:0] gain_reg,
   output codec_ctl_pkg::loop_type loop_mode,
   output logic event_monitor,
   output logic cont_xfer,
   output logic flag_pin,
   output codec_ctl_pkg::chan_type chan_state,
   output logic adc_disable,
   output logic dac_disable,
   output logic power_down,
   output logic adc_16bit,
   output codec_ctl_pkg::gain_type adc_gain,
   output codec_ctl_pkg::gain_type dac_gain
);
   import codec_ctl_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] gain;
      logic flag;
   } state_type;

   // Named view of the mode register, most significant field first
   typedef struct packed {
      loop_type loop;
      logic cont;
      logic flag_sel;
      logic flag_val;
      chan_type chan;
      logic fmt;
   } mode_view_type;

   state_type state_ff;
   state_type nxt_state;
   logic is_write;
   logic [2:0] reg_num;
   logic [7:0] wdata;
   gain_if adc_g ();
   gain_if dac_g ();
   mode_view_type mode_view;

   // ----------------------------------------------------------------
   // Field layout checks
   // ----------------------------------------------------------------
   localparam int REG_NUM_WIDTH = `CW_REG_HI - `CW_REG_LO + 1;
   localparam int CONTENT_WIDTH = `CW_DATA_HI - `CW_DATA_LO + 1;
   localparam int ADC_CODE_WIDTH = `GAIN_ADC_HI - `GAIN_ADC_LO + 1;
   localparam int DAC_CODE_WIDTH = `GAIN_DAC_HI - `GAIN_DAC_LO + 1;

   // The decode assumes a 3-bit register number, 8-bit content and 4-bit gain codes
   if (REG_NUM_WIDTH != 3) begin : g_bad_reg_num
      $error("register number field must be three bits wide");
   end
   if (CONTENT_WIDTH != 8) begin : g_bad_content
      $error("register content field must be eight bits wide");
   end
   if (ADC_CODE_WIDTH != 4) begin : g_bad_adc_code
      $error("input gain code field must be four bits wide");
   end
   if (DAC_CODE_WIDTH != 4) begin : g_bad_dac_code
      $error("output gain code field must be four bits wide");
   end
   if (`REG_NUM_MODE == `REG_NUM_GAIN) begin : g_bad_reg_map
      $error("mode and gain registers need distinct numbers");
   end
   // The named view only holds while the field positions keep their layout
   if ($bits(mode_view_type) != 8 || `MODE_CONT_BIT != 5 || `MODE_FMT_BIT != 0) begin : g_bad_view
      $error("mode register view does not match the field positions");
   end

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic word_writes(input logic valid, input logic [15:0] word);
      return valid && !word[`CW_RW_BIT];
   endfunction : word_writes

   function automatic logic [2:0] word_reg_num(input logic [15:0] word);
      return word[`CW_REG_HI:`CW_REG_LO];
   endfunction : word_reg_num

   function automatic logic [7:0] word_content(input logic [15:0] word);
      return word[`CW_DATA_HI:`CW_DATA_LO];
   endfunction : word_content

   // Numbers other than the two held here fall through silently
   function automatic logic write_hits(input logic wr, input logic [2:0] num,
         input logic [2:0] target);
      return wr && (num == target);
   endfunction : write_hits

   function automatic loop_type loop_field(input logic [7:0] mode);
      return loop_type'(mode[`MODE_LOOP_HI:`MODE_LOOP_LO]);
   endfunction : loop_field

   function automatic chan_type chan_field(input logic [7:0] mode);
      return chan_type'(mode[`MODE_CHAN_HI:`MODE_CHAN_LO]);
   endfunction : chan_field

   // Power-down silences both channels as well as the rest of the device
   function automatic logic adc_is_off(input chan_type c);
      return (c == CHAN_ADC_OFF) || (c == CHAN_PWRDN);
   endfunction : adc_is_off

   function automatic logic dac_is_off(input chan_type c);
      return (c == CHAN_DAC_OFF) || (c == CHAN_PWRDN);
   endfunction : dac_is_off

   function automatic logic [3:0] adc_code(input logic [7:0] gain);
      return gain[`GAIN_ADC_HI:`GAIN_ADC_LO];
   endfunction : adc_code

   function automatic logic [3:0] dac_code(input logic [7:0] gain);
      return gain[`GAIN_DAC_HI:`GAIN_DAC_LO];
   endfunction : dac_code

   // ----------------------------------------------------------------
   // Control word split
   // ----------------------------------------------------------------

   assign is_write = word_writes(word_valid, word_data);
   assign reg_num = word_reg_num(word_data);
   assign wdata = word_content(word_data);
   assign mode_view = mode_view_type'(state_ff.mode);

   // ----------------------------------------------------------------
   // Write decode and flag steering
   // ----------------------------------------------------------------
   always_comb begin
      nxt_state = state_ff;
      // Reads and unknown register numbers leave the mode and gain registers alone
      if (write_hits(is_write, reg_num, `REG_NUM_MODE)) begin
         nxt_state.mode = wdata;
      end
      if (write_hits(is_write, reg_num, `REG_NUM_GAIN)) begin
         nxt_state.gain = wdata;
      end
      // Flag source follows the register contents, one cycle late at the pin
      if (mode_view.flag_sel) begin
         nxt_state.flag = mode_view.flag_val;
      end else begin
         nxt_state.flag = sec_comm_flag;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff.mode <= `MODE_RESET;
         state_ff.gain <= `GAIN_RESET;
         state_ff.flag <= 1'b0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // Loopback and transfer mode
   // ----------------------------------------------------------------
   assign mode_reg = state_ff.mode;
   assign gain_reg = state_ff.gain;
   assign loop_mode = loop_field(state_ff.mode);
   assign event_monitor = (loop_mode == LOOP_EVENT);
   // Only a cascade master may stream; a slave ignores the bit
   assign cont_xfer = mode_view.cont && is_master;

   // ----------------------------------------------------------------
   // Flag pin
   // ----------------------------------------------------------------
   assign flag_pin = state_ff.flag;

   // ----------------------------------------------------------------
   // Channel state and ADC format
   // ----------------------------------------------------------------
   assign chan_state = chan_field(state_ff.mode);
   assign adc_disable = adc_is_off(chan_state);
   assign dac_disable = dac_is_off(chan_state);
   assign power_down = (chan_state == CHAN_PWRDN);
   assign adc_16bit = mode_view.fmt;

   // ----------------------------------------------------------------
   // Amplifier gains
   // ----------------------------------------------------------------
   assign adc_g.code = adc_code(state_ff.gain);
   assign dac_g.code = dac_code(state_ff.gain);
   assign adc_gain = adc_g.gain;
   assign dac_gain = dac_g.gain;

   gain_decode u_adc_gain (
      .g(adc_g.decoder)
   );

   gain_decode u_dac_gain (
      .g(dac_g.decoder)
   );
endmodule : codec_ctl_regs
`default_nettype wire

// ===== sim/host_model.sv
// Host side: issues one 16-bit control word per clock.
// Assumes the caller sits on a falling edge of clk.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk,
   output logic word_valid,
   output logic [15:0] word_data
);
   initial word_valid = 1'b0;
   initial word_data = 16'h0000;
   // Idle words show the inverse so stale data is never mistaken for a word
   task send(input logic v, rd, input logic [2:0] num, input logic [7:0] val);
      word_valid <= v;
      word_data <= v ? {3'h0, rd, num, 1'b0, val} : ~word_data;
      @(negedge clk);
   endtask : send
endmodule : host_model
`default_nettype wire

// ===== sim/codec_ctl_regs_assertions.sv
// Checker for the codec control register bank.
// Bound to every codec_ctl_regs instance.
`timescale 1ns/1ps
`default_nettype none
module ctl_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic word_valid,
   input wire logic [15:0] word_data,
   input wire logic is_master,
   input wire logic sec_comm_flag,
   input wire logic [7:0] mode_reg,
   input wire logic [7:0] gain_reg,
   input wire logic event_monitor,
   input wire logic cont_xfer,
   input wire logic flag_pin,
   input wire logic adc_disable,
   input wire logic dac_disable,
   input wire logic power_down,
   input wire logic adc_16bit
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire wr = word_valid && !word_data[12];
   a_mode_write: assert property (wr && word_data[11:9] == 3'h3 |=>
      mode_reg == $past(word_data[7:0])) else $error("mode write");
   a_gain_write: assert property (wr && word_data[11:9] == 3'h4 |=>
      gain_reg == $past(word_data[7:0])) else $error("gain write");
   a_read_ignored: assert property (word_valid && word_data[12] |=>
      $stable(mode_reg) && $stable(gain_reg)) else $error("read wrote");
   a_event_mode: assert property (
      event_monitor == (mode_reg[7:6] == 2'b11)) else $error("event mode");
   a_cont_gate: assert property (
      cont_xfer == (mode_reg[5] && is_master)) else $error("cont xfer");
   a_flag_source: assert property (!$past(rst) |-> flag_pin == ($past(mode_reg[4]) ?
      $past(mode_reg[3]) : $past(sec_comm_flag))) else $error("flag");
   a_chan_decode: assert property (power_down == &mode_reg[2:1] &&
      adc_disable == mode_reg[1] && dac_disable == mode_reg[2] && adc_16bit == mode_reg[0])
      else $error("chan");
   a_reset_zero: assert property (disable iff (1'b0) rst |=>
      mode_reg == 8'h00 && gain_reg == 8'h00) else $error("reset");
   c_event: cover property (event_monitor);
   c_down: cover property (power_down);
   c_flag: cover property (flag_pin);
endmodule : ctl_chk
bind codec_ctl_regs ctl_chk chk (.*);
`default_nettype wire

// ===== sim/testbench.sv
// Bench: writes control words and checks the decoded outputs.
// Assumes host_model and ctl_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import codec_ctl_pkg::*;
   logic clk = 1'b0, rst = 1'b1, is_master = 1'b0, sec_comm_flag = 1'b0, word_valid;
   logic event_monitor, cont_xfer, flag_pin, adc_disable, dac_disable, power_down, adc_16bit;
   logic [15:0] word_data;
   logic [7:0] mode_reg, gain_reg;
   loop_type loop_mode;
   chan_type chan_state;
   gain_type adc_gain, dac_gain;
   int mismatches = 0, checks_done = 0;
   int db[16] = '{0, -36, -30, -24, -18, -12, -9, -6, -3, 3, 6, 9, 12, 18, 24, 0};
   host_model host (.clk, .word_valid, .word_data);
   codec_ctl_regs uut (.*);
   initial forever #2.5 clk = ~clk;
   task check(input logic [15:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task final_report;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report
   initial begin
      repeat (8) @(negedge clk);
      rst = 1'b0;
      check(mode_reg | gain_reg, 16'h0000);
      // Back-to-back gain words over every code of both nibbles
      for (int i = 0; i < 16; i++) begin
         host.send(1'b1, 1'b0, 3'h4, {4'(i), 4'(15 - i)});
         check(adc_gain, {i == 15, 8'(db[i])});
         check(dac_gain, {i == 0, 8'(db[15 - i])});
      end
      for (int k = 0; k < 4; k++) begin
         is_master = k[0];
         host.send(1'b1, 1'b0, 3'h3, {2'(k), 2'b11, k[1], 2'(k), k[0]});
         check({event_monitor, cont_xfer, power_down, dac_disable, adc_disable, adc_16bit},
            {k == 3, k[0], k == 3, k[1], k[0], k[0]});
         host.send(1'b0, 1'b0, 3'h0, 8'h00);
         check(flag_pin, k[1]);
      end
      host.send(1'b1, 1'b0, 3'h3, 8'h08);
      host.send(1'b0, 1'b0, 3'h0, 8'h00);
      check(flag_pin, 1'b0);
      sec_comm_flag = 1'b1;
      host.send(1'b0, 1'b0, 3'h0, 8'h00);
      check(flag_pin, 1'b1);
      sec_comm_flag = 1'b0;
      host.send(1'b1, 1'b1, 3'h3, 8'hff);
      host.send(1'b1, 1'b0, 3'h5, 8'hff);
      host.send(1'b0, 1'b0, 3'h0, 8'h00);
      check({mode_reg, gain_reg}, 16'h08f0);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      check({mode_reg, gain_reg}, 16'h0000);
      final_report();
   end
   initial begin
      #2000;
      mismatches++;
      final_report();
   end
endmodule : testbench
`default_nettype wire
